// [rtl/ans_cfg.svh]
`ifndef ANS_CFG_SVH
`define ANS_CFG_SVH

// Word, slot and FIFO geometry
`define ANS_WORD_W        16
`define ANS_HALF_W        8
`define ANS_SLOTS         4
`define ANS_FIFO_DEPTH    16
`define ANS_FIFO_AW       4
`define ANS_CNT_W         5

// Routing bit positions
`define ANS_IRQ_ROUTE_BIT 7

// Frame sync length codes and pulse widths in bit clocks
`define ANS_FSL_CODE_6    3'h0
`define ANS_FSL_CODE_13   3'h1
`define ANS_FSL_CODE_14   3'h2
`define ANS_FSL_CODE_15   3'h3
`define ANS_FSL_LEN_6     5'h06
`define ANS_FSL_LEN_13    5'h0d
`define ANS_FSL_LEN_14    5'h0e
`define ANS_FSL_LEN_15    5'h0f
`define ANS_FSL_LEN_16    5'h10

// Last bit index within a slot
`define ANS_LAST_BIT_8    4'h7
`define ANS_LAST_BIT_16   4'hf

// Reset values
`define ANS_RST_FCNT      7'h00
`define ANS_RST_DIV       8'h00

`endif

// [rtl/ans_pkg.sv]
package ans_pkg;
`include "ans_cfg.svh"

  typedef logic [`ANS_WORD_W-1:0] ans_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } ans_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       src_q;
    logic       rise;
    logic       fall;
  } ans_div_t;

  typedef struct packed {
    ans_state_t                                   state;
    logic                                         bclk_q;
    logic                                         fs_q;
    logic                                         rbclk_q;
    logic                                         rfs_q;
    logic [6:0]                                   fcnt;
    logic [2:0]                                   tslot;
    logic [3:0]                                   tbit;
    logic [2:0]                                   rslot;
    logic [3:0]                                   rbit;
    ans_word_t                                    tsh;
    ans_word_t                                    rsh;
    logic [`ANS_FIFO_DEPTH-1:0][`ANS_WORD_W-1:0]  tx_mem;
    logic [`ANS_FIFO_AW-1:0]                      tx_wp;
    logic [`ANS_FIFO_AW-1:0]                      tx_rp;
    logic [`ANS_CNT_W-1:0]                        tx_cnt;
    ans_word_t                                    tx_last;
    logic [`ANS_FIFO_DEPTH-1:0][`ANS_WORD_W-1:0]  rx_mem;
    logic [`ANS_FIFO_AW-1:0]                      rx_wp;
    logic [`ANS_FIFO_AW-1:0]                      rx_rp;
    logic [`ANS_CNT_W-1:0]                        rx_cnt;
    ans_word_t                                    rx_rdata;
    logic [`ANS_SLOTS-1:0][`ANS_WORD_W-1:0]       tx_hold;
    logic [`ANS_SLOTS-1:0]                        tx_full;
    logic [`ANS_SLOTS-1:0][`ANS_WORD_W-1:0]       rx_hold;
    logic [`ANS_SLOTS-1:0]                        rx_full;
    logic                                         bclk_o;
    logic                                         bclk_oe;
    logic                                         fs_o;
    logic                                         fs_oe;
    logic                                         sd_o;
    logic                                         sd_oe;
    logic                                         rbclk_o;
    logic                                         rfs_o;
    logic                                         rpins_oe;
    logic                                         tx_unf;
    logic                                         rx_ovf;
    logic [2*`ANS_SLOTS-1:0]                      dma_req;
    logic [3:0]                                   cpu_dma;
    logic [3:0]                                   dsp_dma;
    logic                                         cpu_irq;
    logic                                         dsp_irq;
  } ans_st_t;

endpackage

// [rtl/ans_clk_div.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ans_cfg.svh"

module ans_clk_div (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_src_sel,
  input  wire logic       aux_clk1,
  input  wire logic       aux_clk8,
  input  wire logic [7:0] bit_clock_divider,
  output logic            bclk_rise,
  output logic            bclk_fall
);
  import ans_pkg::*;

  ans_div_t st_r;
  ans_div_t st_nxt;
  logic     src;
  logic [7:0] half;

  assign src       = clk_src_sel ? aux_clk8 : aux_clk1;
  assign half      = 8'((9'(bit_clock_divider) + 9'h001) >> 1);
  assign bclk_rise = st_r.rise;
  assign bclk_fall = st_r.fall;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.src_q = src;
    st_nxt.rise  = 1'b0;
    st_nxt.fall  = 1'b0;
    if (src && !st_r.src_q) begin
      // Period of divider plus one source cycles
      st_nxt.cnt  = (st_r.cnt == bit_clock_divider) ? 8'h00 : st_r.cnt + 8'h01;
      st_nxt.rise = (st_nxt.cnt == 8'h00);
      st_nxt.fall = (st_nxt.cnt == half) && (half != 8'h00);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r     <= '0;
      st_r.cnt <= `ANS_RST_DIV;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// [rtl/ans_port.sv]
// How it works
// - Slots in a frame share 8/16 length.
// - Frame sync starts frame at slot zero.
// - Up to four slots belong to us.
// - Transmit drives only assigned slots, else released.
// - Per-slot select: transmit FIFO or holding register.
// - Receive keeps assigned-slot words, FIFO or holding.
// - Receive FIFO fill above limit raises interrupt.
// - Transmit FIFO at/below limit raises interrupt.
// - Interrupt gated, route bit 7 picks controller.
// - CPU route appears as request line 27.
// - Receive DMA slot fills holding, requests while full.
// - Transmit DMA slot drains holding, requests while empty.
// - Synchronous mode: receiver uses transmit clock, sync.
// - Extra syncs at slot 1 and 2.
// - Slot 0/1 requests map to routed channels 6-9.
// - DMA requests need the port DMA enable.
// - Bit clock is input over divider plus one.
// - Input clock chosen from two auxiliary clocks.
// - Frame length is divider plus one bits.
// - Sync pulse width 6, 13, 14, 15, 16.
// - Only the master drives clock and sync.
// - Each FIFO holds sixteen words.
// - Empty transmit holding resends previous slot word.
`timescale 1ns/100ps
`default_nettype none
`include "ans_cfg.svh"

module ans_port (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        port_enable,
  input  wire logic                        master_mode,
  input  wire logic                        sync_mode,
  input  wire logic                        word16,
  input  wire logic [1:0]                  slot_count_sel,
  input  wire logic [3:0]                  tx_slot_assign,
  input  wire logic [3:0]                  rx_slot_assign,
  input  wire logic [3:0]                  tx_slot_dma_select,
  input  wire logic [3:0]                  rx_slot_dma_select,
  input  wire logic                        extra_fs_en,
  input  wire logic                        clk_src_sel,
  input  wire logic                        aux_clk1,
  input  wire logic                        aux_clk8,
  input  wire logic [7:0]                  bit_clock_divider,
  input  wire logic [6:0]                  frame_clock_divider,
  input  wire logic [2:0]                  frame_sync_length,
  input  wire logic                        port_irq_enable,
  input  wire logic [3:0]                  rx_warn_limit,
  input  wire logic [3:0]                  tx_warn_limit,
  input  wire logic [7:0]                  subsystem_irq_route,
  input  wire logic                        port_dma_enable,
  input  wire logic [3:0]                  subsystem_dma_route,
  input  wire logic                        tx_fifo_wr,
  input  wire ans_pkg::ans_word_t          tx_fifo_wdata,
  input  wire logic                        rx_fifo_rd,
  output ans_pkg::ans_word_t               rx_fifo_rdata,
  output logic [4:0]                       tx_fifo_count,
  output logic [4:0]                       rx_fifo_count,
  output logic                             tx_underrun,
  output logic                             rx_overrun,
  input  wire logic [3:0]                  tx_dma_wr,
  input  wire ans_pkg::ans_word_t          tx_dma_wdata,
  input  wire logic [3:0]                  rx_dma_rd,
  output logic [63:0]                      rx_slot_dma_holding,
  output logic [7:0]                       dma_req,
  output logic [3:0]                       cpu_dma_req,
  output logic [3:0]                       dsp_dma_req,
  output logic                             cpu_irq27,
  output logic                             dsp_irq,
  input  wire logic                        tx_bit_clock_in,
  output logic                             tx_bit_clock_out,
  output logic                             tx_bit_clock_oe,
  input  wire logic                        tx_frame_sync_in,
  output logic                             tx_frame_sync_out,
  output logic                             tx_frame_sync_oe,
  output logic                             serial_tx_data_out,
  output logic                             serial_tx_data_oe,
  input  wire logic                        serial_rx_data,
  input  wire logic                        rx_bit_clock_in,
  output logic                             rx_bit_clock_out,
  output logic                             rx_bit_clock_oe,
  input  wire logic                        rx_frame_sync_in,
  output logic                             rx_frame_sync_out,
  output logic                             rx_frame_sync_oe
);
  import ans_pkg::*;

  ans_st_t    st_r;
  ans_st_t    st_nxt;
  logic       div_rise;
  logic       div_fall;
  logic       t_rise;
  logic       t_fall;
  logic       r_rise;
  logic       r_fall;
  logic       t_fstart;
  logic       r_fstart;
  logic [3:0] last_bit;
  logic [4:0] fs_len;

  ans_clk_div u_div (
    .core_clk          (core_clk),
    .sys_rst           (sys_rst),
    .clk_src_sel       (clk_src_sel),
    .aux_clk1          (aux_clk1),
    .aux_clk8          (aux_clk8),
    .bit_clock_divider (bit_clock_divider),
    .bclk_rise         (div_rise),
    .bclk_fall         (div_fall)
  );

  // Master uses own divider; slave follows the pins
  assign t_rise   = master_mode ? div_rise : (tx_bit_clock_in && !st_r.bclk_q);
  assign t_fall   = master_mode ? div_fall : (!tx_bit_clock_in && st_r.bclk_q);
  assign r_rise   = sync_mode ? t_rise : (rx_bit_clock_in && !st_r.rbclk_q);
  assign r_fall   = sync_mode ? t_fall : (!rx_bit_clock_in && st_r.rbclk_q);
  assign t_fstart = master_mode ? (st_r.fcnt == frame_clock_divider)
                                : (tx_frame_sync_in && !st_r.fs_q);
  assign r_fstart = sync_mode ? t_fstart : (rx_frame_sync_in && !st_r.rfs_q);
  assign last_bit = word16 ? `ANS_LAST_BIT_16 : `ANS_LAST_BIT_8;

  always_comb begin
    case (frame_sync_length)
      `ANS_FSL_CODE_6:  fs_len = `ANS_FSL_LEN_6;
      `ANS_FSL_CODE_13: fs_len = `ANS_FSL_LEN_13;
      `ANS_FSL_CODE_14: fs_len = `ANS_FSL_LEN_14;
      `ANS_FSL_CODE_15: fs_len = `ANS_FSL_LEN_15;
      default:          fs_len = `ANS_FSL_LEN_16;
    endcase
  end

  // Slot and bit position after one bit clock
  function automatic logic [6:0] slot_adv(input logic fs, input logic [2:0] s,
                                          input logic [3:0] b, input logic [3:0] lb);
    logic [2:0] s_inc;
    s_inc = (s == 3'h7) ? s : s + 3'h1;
    if (fs) begin
      slot_adv = 7'h00;
    end else if (b == lb) begin
      slot_adv = {s_inc, 4'h0};
    end else begin
      slot_adv = {s, b + 4'h1};
    end
  endfunction

  // Slot belongs to this port in this direction
  function automatic logic slot_own(input logic [3:0] asg, input logic [2:0] s,
                                    input logic [1:0] cnt_sel);
    slot_own = (s[2] == 1'b0) && (s[1:0] <= cnt_sel) && asg[s[1:0]];
  endfunction

  always_comb begin
    ans_word_t  tw;
    ans_word_t  rw;
    logic [1:0] k;
    logic       fifo_rx_used;
    logic       fifo_tx_used;
    logic       irq;
    tw           = '0;
    rw           = '0;
    k            = 2'h0;
    fifo_rx_used = 1'b0;
    fifo_tx_used = 1'b0;
    irq          = 1'b0;
    st_nxt       = st_r;
    st_nxt.tx_unf = 1'b0;
    st_nxt.rx_ovf = 1'b0;
    st_nxt.bclk_q  = tx_bit_clock_in;
    st_nxt.rbclk_q = rx_bit_clock_in;
    st_nxt.bclk_oe  = master_mode;
    st_nxt.fs_oe    = master_mode;
    st_nxt.rpins_oe = master_mode && sync_mode && extra_fs_en;
    if (!port_enable) begin
      st_nxt.state = ST_IDLE;
    end

    // Transmit side timing and shifting
    if (t_rise) begin
      st_nxt.fs_q = tx_frame_sync_in;
      if (master_mode) begin
        st_nxt.bclk_o = 1'b1;
        st_nxt.fcnt = t_fstart ? `ANS_RST_FCNT : st_r.fcnt + 7'h01;
        // No sync pulse before the first counter wrap after reset
        st_nxt.fs_o = t_fstart
                      || (st_r.fs_o && ({1'b0, st_nxt.fcnt} < {3'b000, fs_len}));
      end
      if (t_fstart && port_enable) begin
        st_nxt.state = ST_RUN;
      end
      {st_nxt.tslot, st_nxt.tbit} = slot_adv(t_fstart, st_r.tslot, st_r.tbit, last_bit);
      st_nxt.rbclk_o = (st_nxt.tslot == 3'h1) && ({1'b0, st_nxt.tbit} < fs_len);
      st_nxt.rfs_o   = (st_nxt.tslot == 3'h2) && ({1'b0, st_nxt.tbit} < fs_len);
      k = st_nxt.tslot[1:0];
      if (st_nxt.state == ST_RUN && slot_own(tx_slot_assign, st_nxt.tslot, slot_count_sel)) begin
        if (st_nxt.tbit == 4'h0) begin
          if (tx_slot_dma_select[k]) begin
            tw = st_r.tx_hold[k];
            st_nxt.tx_full[k] = 1'b0;
          end else if (st_r.tx_cnt != 5'h00) begin
            tw = st_r.tx_mem[st_r.tx_rp];
            st_nxt.tx_rp   = st_r.tx_rp + 4'h1;
            st_nxt.tx_cnt  = st_r.tx_cnt - 5'h01;
            st_nxt.tx_last = tw;
          end else begin
            tw = st_r.tx_last;
            st_nxt.tx_unf = 1'b1;
          end
          st_nxt.tsh = word16 ? tw : {tw[`ANS_HALF_W-1:0], 8'h00};
        end else begin
          st_nxt.tsh = {st_r.tsh[`ANS_WORD_W-2:0], 1'b0};
        end
        st_nxt.sd_o  = st_nxt.tsh[`ANS_WORD_W-1];
        st_nxt.sd_oe = 1'b1;
      end else begin
        st_nxt.sd_oe = 1'b0;
      end
    end
    if (t_fall && master_mode) begin
      st_nxt.bclk_o = 1'b0;
    end
    if (!port_enable) begin
      st_nxt.sd_oe = 1'b0;
    end

    // Software side of transmit and receive buffers; a same-cycle drain makes room for a write
    if (tx_fifo_wr && st_nxt.tx_cnt != 5'h10) begin
      st_nxt.tx_mem[st_r.tx_wp] = tx_fifo_wdata;
      st_nxt.tx_wp  = st_r.tx_wp + 4'h1;
      st_nxt.tx_cnt = st_nxt.tx_cnt + 5'h01;
    end
    for (int i = 0; i < `ANS_SLOTS; i++) begin
      if (tx_dma_wr[i]) begin
        st_nxt.tx_hold[i] = tx_dma_wdata;
        st_nxt.tx_full[i] = 1'b1;
      end
      if (rx_dma_rd[i]) begin
        st_nxt.rx_full[i] = 1'b0;
      end
    end
    if (rx_fifo_rd && st_r.rx_cnt != 5'h00) begin
      st_nxt.rx_rdata = st_r.rx_mem[st_r.rx_rp];
      st_nxt.rx_rp  = st_r.rx_rp + 4'h1;
      st_nxt.rx_cnt = st_r.rx_cnt - 5'h01;
    end

    // Receive side timing and capture
    if (r_rise) begin
      st_nxt.rfs_q = rx_frame_sync_in;
      {st_nxt.rslot, st_nxt.rbit} = slot_adv(r_fstart, st_r.rslot, st_r.rbit, last_bit);
    end
    if (r_fall && st_r.state == ST_RUN
        && slot_own(rx_slot_assign, st_r.rslot, slot_count_sel)) begin
      st_nxt.rsh = {st_r.rsh[`ANS_WORD_W-2:0], serial_rx_data};
      if (st_r.rbit == last_bit) begin
        rw = word16 ? st_nxt.rsh : {8'h00, st_nxt.rsh[`ANS_HALF_W-1:0]};
        k  = st_r.rslot[1:0];
        if (rx_slot_dma_select[k]) begin
          st_nxt.rx_hold[k] = rw;
          st_nxt.rx_full[k] = 1'b1;
        end else if (st_nxt.rx_cnt != 5'h10) begin
          st_nxt.rx_mem[st_r.rx_wp] = rw;
          st_nxt.rx_wp  = st_r.rx_wp + 4'h1;
          st_nxt.rx_cnt = st_nxt.rx_cnt + 5'h01;
        end else begin
          st_nxt.rx_ovf = 1'b1;
        end
      end
    end

    // Interrupt and its routing
    fifo_rx_used = |(rx_slot_assign & ~rx_slot_dma_select);
    fifo_tx_used = |(tx_slot_assign & ~tx_slot_dma_select);
    irq = port_irq_enable &&
          ((fifo_rx_used && st_nxt.rx_cnt > {1'b0, rx_warn_limit}) ||
           (fifo_tx_used && st_nxt.tx_cnt <= {1'b0, tx_warn_limit}));
    st_nxt.cpu_irq = irq && !subsystem_irq_route[`ANS_IRQ_ROUTE_BIT];
    st_nxt.dsp_irq = irq && subsystem_irq_route[`ANS_IRQ_ROUTE_BIT];

    // DMA requests and routing of slots 0 and 1
    for (int i = 0; i < `ANS_SLOTS; i++) begin
      st_nxt.dma_req[2*i]   = port_dma_enable && rx_slot_dma_select[i]
                              && st_nxt.rx_full[i];
      st_nxt.dma_req[2*i+1] = port_dma_enable && tx_slot_dma_select[i]
                              && !st_nxt.tx_full[i];
    end
    for (int j = 0; j < 4; j++) begin
      st_nxt.cpu_dma[j] = st_nxt.dma_req[j] && !subsystem_dma_route[j];
      st_nxt.dsp_dma[j] = st_nxt.dma_req[j] && subsystem_dma_route[j];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r       <= '0;
      st_r.state <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rx_fifo_rdata       = st_r.rx_rdata;
  assign tx_fifo_count       = st_r.tx_cnt;
  assign rx_fifo_count       = st_r.rx_cnt;
  assign tx_underrun         = st_r.tx_unf;
  assign rx_overrun          = st_r.rx_ovf;
  assign rx_slot_dma_holding = st_r.rx_hold;
  assign dma_req             = st_r.dma_req;
  assign cpu_dma_req         = st_r.cpu_dma;
  assign dsp_dma_req         = st_r.dsp_dma;
  assign cpu_irq27           = st_r.cpu_irq;
  assign dsp_irq             = st_r.dsp_irq;
  assign tx_bit_clock_out    = st_r.bclk_o;
  assign tx_bit_clock_oe     = st_r.bclk_oe;
  assign tx_frame_sync_out   = st_r.fs_o;
  assign tx_frame_sync_oe    = st_r.fs_oe;
  assign serial_tx_data_out  = st_r.sd_o;
  assign serial_tx_data_oe   = st_r.sd_oe;
  assign rx_bit_clock_out    = st_r.rbclk_o;
  assign rx_bit_clock_oe     = st_r.rpins_oe;
  assign rx_frame_sync_out   = st_r.rfs_o;
  assign rx_frame_sync_oe    = st_r.rpins_oe;

endmodule
`default_nettype wire

// [testbench/ans_port_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module ans_port_monitor (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       master_mode,
  input wire logic       sync_mode,
  input wire logic       extra_fs_en,
  input wire logic       port_enable,
  input wire logic       port_irq_enable,
  input wire logic       port_dma_enable,
  input wire logic [7:0] subsystem_irq_route,
  input wire logic [3:0] subsystem_dma_route,
  input wire logic [3:0] rx_slot_dma_select,
  input wire logic [7:0] dma_req,
  input wire logic [3:0] cpu_dma_req,
  input wire logic       cpu_irq27,
  input wire logic       dsp_irq,
  input wire logic       tx_bit_clock_oe,
  input wire logic       tx_frame_sync_oe,
  input wire logic       rx_bit_clock_oe,
  input wire logic       serial_tx_data_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic up_r;
  always_ff @(posedge core_clk) up_r <= !sys_rst;
  property p_mst_oe;
    up_r |-> {tx_bit_clock_oe, tx_frame_sync_oe} == {2{$past(master_mode)}};
  endproperty
  a_mst_oe: assert property (p_mst_oe) else $error("clock pin enable");
  property p_xfs_oe;
    up_r |-> rx_bit_clock_oe == $past(master_mode && sync_mode && extra_fs_en);
  endproperty
  a_xfs_oe: assert property (p_xfs_oe) else $error("extra sync enable");
  property p_irq_cpu;
    cpu_irq27 |-> $past(port_irq_enable) && !$past(subsystem_irq_route[7]);
  endproperty
  a_irq_cpu: assert property (p_irq_cpu) else $error("cpu irq route");
  property p_irq_dsp;
    dsp_irq |-> $past(port_irq_enable) && $past(subsystem_irq_route[7]);
  endproperty
  a_irq_dsp: assert property (p_irq_dsp) else $error("dsp irq route");
  property p_dma_en; dma_req != 8'h00 |-> $past(port_dma_enable); endproperty
  a_dma_en: assert property (p_dma_en) else $error("dma without enable");
  property p_dma_rt;
    up_r && $stable(subsystem_dma_route) && $stable(dma_req)
      |-> cpu_dma_req == (dma_req[3:0] & ~subsystem_dma_route);
  endproperty
  a_dma_rt: assert property (p_dma_rt) else $error("dma route");
  property p_rx_sel; dma_req[2] |-> $past(rx_slot_dma_select[1]); endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("rx dma select");
  property p_sd_off; !port_enable [*2] |-> !serial_tx_data_oe; endproperty
  a_sd_off: assert property (p_sd_off) else $error("data driven idle");
  c_cpu_irq: cover property (cpu_irq27);
  c_dsp_irq: cover property (dsp_irq);
  c_sd_on: cover property ($rose(serial_tx_data_oe));
endmodule
`default_nettype wire

// [testbench/ans_codec_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ans_codec_model #(
  parameter logic [7:0] RX_WORD = 8'h96
) (
  input  wire logic core_clk,
  input  wire logic bclk,
  input  wire logic fs,
  input  wire logic xfs1,
  input  wire logic xfs2,
  input  wire logic sd_in,
  input  wire logic sd_oe,
  output logic       sd_out,
  output logic [7:0] tx_word,
  output logic [7:0] tx_n,
  output logic [4:0] fs_w,
  output logic [4:0] x1_at,
  output logic [4:0] x2_at,
  output logic [4:0] flen,
  output logic       oe_bad
);
  logic bq = 0, fq = 0, x1q = 0, x2q = 0, on = 0;
  logic [4:0] idx = 0, fsc = 0;
  logic [7:0] sh = 0;
  initial {sd_out, tx_word, tx_n, fs_w, x1_at, x2_at, flen, oe_bad} = '0;
  // Slave: only listens to clock and sync
  always @(posedge core_clk) begin
    if (bclk && !bq) begin
      if (fs && !fq) begin
        flen <= idx + 5'h01;
        idx = 5'h00;
        on = 1'b1;
      end else begin
        idx = idx + 5'h01;
      end
      if (fs) fsc = fq ? fsc + 5'h01 : 5'h01;
      // Eight-bit slot 1 is ours, toggling sd_out otherwise
      if (idx >= 5'h08 && idx < 5'h10) sd_out <= RX_WORD[5'h0f - idx];
      else sd_out <= ~sd_out;
    end
    if (!bclk && bq && on) begin
      if ((idx < 5'h07 && !sd_oe) || (idx >= 5'h08 && sd_oe)) oe_bad <= 1'b1;
      if (idx < 5'h08) sh = {sh[6:0], sd_in};
      if (idx == 5'h07) begin
        tx_word <= sh;
        tx_n <= tx_n + 8'h01;
      end
    end
    if (!fs && fq) fs_w <= fsc;
    if (xfs1 && !x1q) x1_at <= idx;
    if (xfs2 && !x2q) x2_at <= idx;
    {bq, fq, x1q, x2q} = {bclk, fs, xfs1, xfs2};
  end
endmodule
`default_nettype wire

// [testbench/test_ans_port.sv]
`timescale 1ns/100ps
`default_nettype none
module test_ans_port;
  import ans_pkg::*;
  logic core_clk = 0, sys_rst = 1, port_enable = 0, master_mode = 1, sync_mode = 1;
  logic word16 = 0, extra_fs_en = 1, clk_src_sel = 0, aux_clk1 = 0, aux_clk8 = 0;
  logic port_irq_enable = 1, port_dma_enable = 0, tx_fifo_wr = 0, rx_fifo_rd = 0;
  logic [1:0] slot_count_sel = 2'h2;
  logic [2:0] frame_sync_length = 3'h0;
  logic [3:0] tx_slot_assign = 4'h1, rx_slot_assign = 4'h2, tx_slot_dma_select = 4'h0;
  logic [3:0] rx_slot_dma_select = 4'h0, rx_warn_limit = 4'hf, tx_warn_limit = 4'h0;
  logic [3:0] subsystem_dma_route = 4'h4, tx_dma_wr = 4'h0, rx_dma_rd = 4'h0;
  logic [6:0] frame_clock_divider = 7'h17;
  logic [7:0] bit_clock_divider = 8'h01, subsystem_irq_route = 8'h00;
  ans_word_t tx_fifo_wdata = 16'h0000, tx_dma_wdata = 16'h0000, rx_fifo_rdata;
  logic [4:0] tx_fifo_count, rx_fifo_count, fs_w, x1_at, x2_at, flen;
  logic [7:0] dma_req, tx_word, tx_n;
  logic [3:0] cpu_dma_req, dsp_dma_req;
  logic [63:0] rx_slot_dma_holding;
  logic tx_underrun, rx_overrun, cpu_irq27, dsp_irq, oe_bad, serial_rx_data;
  logic tx_bit_clock_out, tx_bit_clock_oe, tx_frame_sync_out, tx_frame_sync_oe;
  logic serial_tx_data_out, serial_tx_data_oe, rx_bit_clock_out, rx_bit_clock_oe;
  logic rx_frame_sync_out, rx_frame_sync_oe;
  wire tx_bit_clock_in = tx_bit_clock_oe & tx_bit_clock_out;
  wire tx_frame_sync_in = tx_frame_sync_oe & tx_frame_sync_out;
  wire rx_bit_clock_in = rx_bit_clock_oe & rx_bit_clock_out;
  wire rx_frame_sync_in = rx_frame_sync_oe & rx_frame_sync_out;
  int errors = 0, n_checks = 0;
  always #5 core_clk = ~core_clk;
  always #20 aux_clk1 = ~aux_clk1;
  always #40 aux_clk8 = ~aux_clk8;
  ans_port i_ans_port (.*);
  ans_codec_model i_ans_codec_model (.core_clk, .bclk(tx_bit_clock_in),
    .fs(tx_frame_sync_in), .xfs1(rx_bit_clock_in), .xfs2(rx_frame_sync_in),
    .sd_in(serial_tx_data_out), .sd_oe(serial_tx_data_oe), .sd_out(serial_rx_data),
    .tx_word, .tx_n, .fs_w, .x1_at, .x2_at, .flen, .oe_bad);
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic frames(input int n);
    logic [7:0] t;
    int k;
    t = tx_n + 8'(n);
    k = 0;
    while (tx_n != t && k < 500 * n) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 500 * n) begin
      errors++;
      $display("BAD %0t no frame seen", $time);
      results;
    end
  endtask
  task automatic put(input logic [15:0] w);
    tx_fifo_wdata = w;
    tx_fifo_wr = 1;
    gap(1);
    tx_fifo_wr = 0;
    gap(1);
  endtask
  task automatic t_reset;
    chk({tx_bit_clock_oe, serial_tx_data_oe, cpu_irq27, dma_req}, 16'h0000);
  endtask
  task automatic t_tx;
    put(16'h00a5);
    put(16'h003c);
    port_enable = 1;
    frames(1);
    chk(tx_word, 8'ha5);
    frames(1);
    chk(tx_word, 8'h3c);
    chk(flen, 5'h18);
    chk(oe_bad, 1'b0);
  endtask
  task automatic t_rx;
    chk(rx_fifo_count != 5'h00, 1'b1);
    rx_fifo_rd = 1;
    gap(1);
    rx_fifo_rd = 0;
    gap(1);
    chk(rx_fifo_rdata[7:0], 8'h96);
  endtask
  task automatic t_irq;
    frames(1);
    chk({cpu_irq27, dsp_irq}, 2'b10);
    subsystem_irq_route = 8'h80;
    gap(2);
    chk({cpu_irq27, dsp_irq}, 2'b01);
    port_irq_enable = 0;
    gap(2);
    chk({cpu_irq27, dsp_irq}, 2'b00);
    port_irq_enable = 1;
    put(16'h00c3);
    chk(dsp_irq, 1'b0);
    rx_warn_limit = 4'h0;
    gap(2);
    chk(dsp_irq, 1'b1);
  endtask
  task automatic t_dma;
    port_dma_enable = 1;
    rx_slot_dma_select = 4'h2;
    tx_slot_dma_select = 4'h1;
    gap(2);
    chk({dma_req[1], cpu_dma_req[1]}, 2'b11);
    tx_dma_wdata = 16'h005a;
    tx_dma_wr = 4'h1;
    gap(1);
    tx_dma_wr = 4'h0;
    gap(1);
    chk(dma_req[1], 1'b0);
    frames(3);
    chk({tx_word, dma_req[1]}, 9'h0b5);
    chk({dma_req[2], dsp_dma_req[2], rx_slot_dma_holding[23:16]}, 10'h396);
    rx_dma_rd = 4'h2;
    gap(1);
    rx_dma_rd = 4'h0;
    gap(1);
    chk(dma_req[2], 1'b0);
    port_dma_enable = 0;
    gap(2);
    chk(dma_req, 8'h00);
  endtask
  task automatic t_fsl;
    logic [4:0] w [5] = '{5'h06, 5'h0d, 5'h0e, 5'h0f, 5'h10};
    for (int c = 0; c < 5; c++) begin
      frame_sync_length = 3'(c);
      frames(2);
      chk(fs_w, w[c]);
    end
    chk({x1_at, x2_at}, {5'h08, 5'h10});
  endtask
  task automatic t_norm;
    slot_count_sel = 2'h0;
    rx_slot_assign = 4'h1;
    rx_slot_dma_select = 4'h1;
    tx_slot_dma_select = 4'h0;
    frames(1);
    chk(tx_word, 8'hc3);
    chk(rx_slot_dma_holding[7:0], 8'haa);
    chk(oe_bad, 1'b0);
  endtask
  task automatic t_clk(input logic s, input int want);
    logic [7:0] t;
    int c;
    clk_src_sel = s;
    frames(2);
    t = tx_n;
    c = 0;
    while (tx_n == t && c < 1000) begin
      @(negedge core_clk);
      c++;
    end
    chk(16'(c), 16'(want));
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    t_reset;
    sys_rst = 0;
    t_tx;
    t_rx;
    t_irq;
    t_dma;
    t_fsl;
    t_norm;
    t_clk(1'b0, 24 * 2 * 4);
    t_clk(1'b1, 24 * 2 * 8);
    results;
  end
endmodule
bind ans_port ans_port_monitor i_ans_port_monitor (.*);
`default_nettype wire
